// *** rtl/sicr_pkg.sv ***
/*
  Constants and carrier types for the serial interface configuration register group.
  Assumes an enclosing serial port engine that presents register writes, reads and per-byte
  address stepping requests in the i_clk domain.
*/
// Overview of operation
// [RL1] Both soft reset bits together reset others
// [RL2] One soft reset bit alone does nothing
// [RL3] Setup A powers up as 0x10
// [RL4] Direction zero steps address down per byte
// [RL5] Direction one steps address up per byte
// [RL6] Setup B bit 7: streaming or single
// [RL7] Streaming steps address per data byte
// [RL8] Nonzero loop count returns to start address
// [RL9] Setup B bit 3 picks 7/15-bit address
// [RL10] Setup B powers up as 0x08
// [RL11] Compat register resets to 0x00
// [RL12] Compat register read-only zero, no effect
// [RL13] Serial-out-on bit reads one, ignores writes
// [RL14] Reserved bits read zero, writes ignored
package sicr_pkg;
  localparam int          SICR_AW           = 15;
  localparam logic [14:0] SICR_OFS_SETUP_A  = 15'h0000;
  localparam logic [14:0] SICR_OFS_SETUP_B  = 15'h0001;
  localparam logic [14:0] SICR_OFS_COMPAT   = 15'h0002;
  localparam logic [14:0] SICR_ADDR_MAX     = 15'h7FFF;
  localparam logic [14:0] SICR_ADDR_MAX_SH  = 15'h007F;
  localparam logic [7:0]  SICR_RST_SETUP_A  = 8'h10;
  localparam logic [7:0]  SICR_RST_SETUP_B  = 8'h08;
  localparam logic [7:0]  SICR_RST_COMPAT   = 8'h00;
  localparam logic [7:0]  SICR_WMASK_A      = 8'h21;
  localparam logic [7:0]  SICR_WMASK_B      = 8'h88;
  localparam int          SICR_BIT_RST_UP   = 7;
  localparam int          SICR_BIT_RST_LO   = 0;
  localparam int          SICR_BIT_ADDR_UP  = 5;
  localparam int          SICR_BIT_SOUT_ON  = 4;
  localparam int          SICR_BIT_SINGLE   = 7;
  localparam int          SICR_BIT_SHORT    = 3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } sicr_req_type;

  typedef struct packed {
    logic addr_up;
    logic single_instr;
    logic short_addr;
    logic serial_out_on;
  } sicr_cfg_type;
endpackage

// *** rtl/sicr_addr_step.sv ***
/*
  Address sequencer for multi-byte data phases.
  Assumes one i_byte_done pulse per data byte and an i_start pulse carrying the start address.
*/
`timescale 1ns/100ps
`default_nettype none
module sicr_addr_step
  import sicr_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Control
  input  wire sicr_cfg_type  i_cfg,
  input  wire logic [7:0]    i_loop_len,
  input  wire logic          i_start,
  input  wire logic [14:0]   i_start_addr,
  input  wire logic          i_byte_done,
  // Result
  output logic [14:0]        o_addr
);
  logic [14:0] addr_r;
  logic [14:0] start_r;
  logic [7:0]  cnt_r;
  logic [14:0] lim;

  // Stepping wraps at the top of the selected address space
  assign lim = i_cfg.short_addr ? SICR_ADDR_MAX_SH : SICR_ADDR_MAX; // RL9

  function automatic logic [14:0] step(input logic [14:0] a, input logic up, input logic [14:0] top);
    if (up) begin
      step = (a >= top) ? 15'h0000 : a + 15'h0001; // RL5
    end else begin
      step = (a == 15'h0000) ? top : a - 15'h0001; // RL4
    end
  endfunction

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_r  <= 15'h0000;
      start_r <= 15'h0000;
      cnt_r   <= 8'h00;
    end else if (i_start) begin
      addr_r  <= i_start_addr;
      start_r <= i_start_addr;
      cnt_r   <= 8'h00;
    end else if (i_byte_done && !i_cfg.single_instr) begin // RL7
      if (i_loop_len != 8'h00 && cnt_r + 8'h01 == i_loop_len) begin // RL8
        addr_r <= start_r;
        cnt_r  <= 8'h00;
      end else begin
        addr_r <= step(addr_r, i_cfg.addr_up, lim);
        cnt_r  <= cnt_r + 8'h01;
      end
    end
  end

  assign o_addr = addr_r;
endmodule
`default_nettype wire

// *** rtl/sicr_regs.sv ***
/*
  Interface configuration registers: setup A, setup B and the compatibility register.
  Assumes the serial port engine issues single-cycle write and read strobes in the i_clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sicr_regs
  import sicr_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Register access from the serial port engine
  input  wire sicr_req_type  i_req,
  // Address stepping
  input  wire logic [7:0]    i_loop_len,
  input  wire logic          i_start,
  input  wire logic [14:0]   i_start_addr,
  input  wire logic          i_byte_done,
  // Results
  output logic [7:0]         o_rdata,
  output logic               o_rvalid,
  output sicr_cfg_type       o_cfg,
  output logic [14:0]        o_addr,
  output logic               o_soft_reset
);
  logic [7:0]   setup_a_r;
  logic [7:0]   setup_b_r;
  logic [7:0]   rdata_r;
  logic         rvalid_r;
  logic         soft_rst_r;
  logic         soft_rst_nxt;
  logic         wr_a;
  logic         wr_b;
  sicr_cfg_type cfg_r;
  sicr_cfg_type cfg_nxt;
  logic [14:0]  step_addr;

  assign wr_a = i_req.wr && i_req.addr == SICR_OFS_SETUP_A;
  assign wr_b = i_req.wr && i_req.addr == SICR_OFS_SETUP_B;

  // Only a write carrying both reset bits in the same byte counts
  assign soft_rst_nxt = wr_a && i_req.wdata[SICR_BIT_RST_UP] && i_req.wdata[SICR_BIT_RST_LO]; // RL1 RL2

  // Reset bits self-clear, so stored A only keeps direction; serial-out-on is constant
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      setup_a_r <= SICR_RST_SETUP_A; // RL3
    end else if (wr_a) begin
      setup_a_r <= (i_req.wdata & SICR_WMASK_A & ~8'h81) | SICR_RST_SETUP_A; // RL13 RL14
    end
  end

  // Setup A is exempt from soft reset, setup B is not
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      setup_b_r <= SICR_RST_SETUP_B; // RL10
    end else if (soft_rst_r) begin
      setup_b_r <= SICR_RST_SETUP_B; // RL1
    end else if (wr_b) begin
      setup_b_r <= i_req.wdata & SICR_WMASK_B; // RL6 RL9 RL14
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_rst_nxt;
    end
  end

  always_comb begin
    cfg_nxt.addr_up       = setup_a_r[SICR_BIT_ADDR_UP];
    cfg_nxt.serial_out_on = setup_a_r[SICR_BIT_SOUT_ON];
    cfg_nxt.single_instr  = setup_b_r[SICR_BIT_SINGLE];
    cfg_nxt.short_addr    = setup_b_r[SICR_BIT_SHORT];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Compatibility register has no storage: constant zero, writes dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_req.rd;
      if (i_req.rd) begin
        case (i_req.addr)
          SICR_OFS_SETUP_A: rdata_r <= setup_a_r;
          SICR_OFS_SETUP_B: rdata_r <= setup_b_r;
          SICR_OFS_COMPAT:  rdata_r <= SICR_RST_COMPAT; // RL11 RL12
          default:          rdata_r <= 8'h00;
        endcase
      end
    end
  end

  sicr_addr_step u_step (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_cfg        (cfg_nxt),
    .i_loop_len   (i_loop_len),
    .i_start      (i_start),
    .i_start_addr (i_start_addr),
    .i_byte_done  (i_byte_done),
    .o_addr       (step_addr)
  );

  assign o_rdata      = rdata_r;
  assign o_rvalid     = rvalid_r;
  assign o_cfg        = cfg_r;
  assign o_addr       = step_addr;
  assign o_soft_reset = soft_rst_r;
endmodule
`default_nettype wire

// *** verif/sicr_host.sv ***
/* Host model: turns a one-cycle go into a register request. Assumes the bench pulses go. */
`timescale 1ns/100ps
`default_nettype none
module sicr_host import sicr_pkg::*; (
  input  wire logic         i_clk,
  input  wire logic         i_go,
  input  wire logic         i_short,
  input  wire sicr_req_type i_cmd,
  output sicr_req_type      o_req
);
  always_ff @(posedge i_clk) begin
    o_req <= '0;
    if (i_go) begin
      o_req <= i_cmd;
      o_req.addr <= i_cmd.addr & (i_short ? 15'h007F : 15'h7FFF);
    end
  end
endmodule
`default_nettype wire

// *** verif/sicr_regs_sva.sv ***
/* Port checker for sicr_regs. Assumes one clock and async reset. */
`timescale 1ns/100ps
`default_nettype none
module sicr_regs_sva
  import sicr_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Watched inputs
  input  wire sicr_req_type  i_req,
  input  wire logic [7:0]    i_loop_len,
  input  wire logic          i_start,
  input  wire logic [14:0]   i_start_addr,
  input  wire logic          i_byte_done,
  // Watched outputs
  input  wire logic [7:0]    o_rdata,
  input  wire logic          o_rvalid,
  input  wire sicr_cfg_type  o_cfg,
  input  wire logic [14:0]   o_addr,
  input  wire logic          o_soft_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire both = i_req.wr && i_req.addr == 15'h0000 && i_req.wdata[7] && i_req.wdata[0];
  sequence s_step;
    // o_cfg lags the stepper's view by a cycle just after a write or soft reset
    i_byte_done && !i_start && $stable(o_cfg) && i_loop_len == 8'h00 && !$past(i_req.wr) && !$past(o_soft_reset);
  endsequence
  property p_srst; both |=> o_soft_reset; endproperty
  a_srst: assert property (p_srst) else $error("no reset pulse");
  property p_one; o_soft_reset |-> $past(both); endproperty
  a_one: assert property (p_one) else $error("stray reset");
  property p_dn;
    s_step ##0 !o_cfg.single_instr && !o_cfg.addr_up && o_addr != 15'h0000 |=> o_addr == $past(o_addr) - 15'h0001;
  endproperty
  a_dn: assert property (p_dn) else $error("bad down step");
  property p_up;
    s_step ##0 !o_cfg.single_instr && o_cfg.addr_up && o_addr < (o_cfg.short_addr ? SICR_ADDR_MAX_SH : SICR_ADDR_MAX)
      |=> o_addr == $past(o_addr) + 15'h0001;
  endproperty
  a_up: assert property (p_up) else $error("bad up step");
  property p_sgl; s_step ##0 o_cfg.single_instr |=> $stable(o_addr); endproperty
  a_sgl: assert property (p_sgl) else $error("single stepped");
  property p_go; i_start |=> o_addr == $past(i_start_addr); endproperty
  a_go: assert property (p_go) else $error("bad start");
  property p_cmp; i_req.rd && i_req.addr == 15'h0002 |=> o_rvalid && o_rdata == 8'h00; endproperty
  a_cmp: assert property (p_cmp) else $error("compat not zero");
  property p_son; !$past(i_rst) |-> o_cfg.serial_out_on; endproperty
  a_son: assert property (p_son) else $error("serial out off");
endmodule
bind sicr_regs sicr_regs_sva u_sva (
  .i_clk        (i_clk),
  .i_rst        (i_rst),
  .i_req        (i_req),
  .i_loop_len   (i_loop_len),
  .i_start      (i_start),
  .i_start_addr (i_start_addr),
  .i_byte_done  (i_byte_done),
  .o_rdata      (o_rdata),
  .o_rvalid     (o_rvalid),
  .o_cfg        (o_cfg),
  .o_addr       (o_addr),
  .o_soft_reset (o_soft_reset)
);
`default_nettype wire

// *** verif/tb_sicr_regs.sv ***
/* Bench for sicr_regs. Assumes rtl and host model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_sicr_regs;
  import sicr_pkg::*;
  logic         i_clk = 0, i_rst = 1, go = 0, st = 0, bd = 0, rv, sr;
  logic [7:0]   ll = 0, rdat;
  logic [14:0]  sad = 0, sa, ad;
  sicr_req_type cmd = '0, req;
  sicr_cfg_type cfg;
  int           errors = 0, compares = 0, seed = 32'h77C5, m, k;
  always #10 i_clk = ~i_clk;
  sicr_host u_host (.i_clk(i_clk), .i_go(go), .i_short(cfg.short_addr), .i_cmd(cmd), .o_req(req));
  sicr_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_loop_len(ll), .i_start(st), .i_start_addr(sad),
    .i_byte_done(bd), .o_rdata(rdat), .o_rvalid(rv), .o_cfg(cfg), .o_addr(ad), .o_soft_reset(sr));
  task stop_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [14:0] g, e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [14:0] a, input logic [7:0] d);
    @(posedge i_clk);
    cmd <= '{w, !w, a, d};
    go <= 1;
    @(posedge i_clk);
    go <= 0;
    @(posedge i_clk);
    #1;
  endtask
  task r(input logic [14:0] a, input logic [7:0] e);
    acc(0, a, 8'h00);
    chk({6'h00, rv, rdat}, {7'h01, e});
  endtask
  // Expected address after k bytes; loop length only counts in streaming
  function automatic logic [14:0] xa(logic [14:0] s, int k, int md, logic [7:0] l);
    int off;
    off = md[2] ? 0 : (l != 0 ? k % l : k);
    xa = (md[0] ? s + off : s - off) & (md[1] ? 15'h007F : 15'h7FFF);
  endfunction
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 0;
    r(15'h0000, 8'h10);
    r(15'h0001, 8'h08);
    r(15'h0002, 8'h00);
    chk({11'h000, cfg}, {11'h000, 4'h3});
    acc(1, 15'h0000, 8'h7E);
    r(15'h0000, 8'h30);
    acc(1, 15'h0001, 8'hFF);
    r(15'h0001, 8'h88);
    acc(1, 15'h0002, 8'hFF);
    r(15'h0002, 8'h00);
    $display("access test done");
    acc(1, 15'h0000, 8'h01);
    acc(1, 15'h0000, 8'h80);
    r(15'h0001, 8'h88);
    acc(1, 15'h0000, 8'h81);
    chk({14'h0000, sr}, 15'h0001);
    r(15'h0001, 8'h08);
    r(15'h0000, 8'h10);
    $display("soft reset test done");
    for (m = 0; m < 6; m++) begin
      acc(1, 15'h0000, {2'b00, m[0], 5'h00});
      acc(1, 15'h0001, {m[2], 3'b000, m[1], 3'b000});
      // First two modes start next to the address space limits to force a wrap
      sa = m < 2 ? (m[0] ? 15'h7FFD : 15'h0002) : 15'($random(seed)) & (m[1] ? 15'h007F : 15'h7FFF);
      k = $random(seed);
      @(posedge i_clk);
      // Up-stepping short stream always loops; the other streams run without a loop
      ll <= (m == 3) ? 8'h02 + 8'(k[1:0]) : (m < 3 ? 8'h00 : 8'(k[1:0]));
      st <= 1;
      sad <= sa;
      #1 chk({11'h000, cfg}, {11'h000, m[0], m[2], m[1], 1'b1});
      for (k = 0; k < 9; k++) begin
        @(posedge i_clk);
        st <= 0;
        bd <= 1;
        #1 chk(ad, xa(sa, k, m, ll));
      end
      @(posedge i_clk);
      bd <= 0;
      $display("step test %0d done", m);
    end
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    stop_test;
  end
endmodule
`default_nettype wire
